//--- inc/pwgdl_defines.vh
// Constants for the parameter write guard and direction lock block.
// Included by the design file; holds definitions only.
`ifndef PWGDL_DEFINES_VH
`define PWGDL_DEFINES_VH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define PWGDL_PNUM_W 10
`define PWGDL_VAL_W 16
`define PWGDL_ADDR_W 8
`define PWGDL_CNT_W 16

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PWGDL_OFF_WPS 8'h00
`define PWGDL_OFF_DLS 8'h04
`define PWGDL_OFF_UGRS 8'h08
`define PWGDL_OFF_DIRCMD 8'h0c
`define PWGDL_OFF_STATUS 8'h10
`define PWGDL_OFF_REJCNT 8'h14
`define PWGDL_OFF_LASTREJ 8'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PWGDL_DIR_FWD 0
`define PWGDL_DIR_REV 1
`define PWGDL_ST_RUN 0
`define PWGDL_ST_PU 1
`define PWGDL_ST_FWD 2
`define PWGDL_ST_REV 3

// ---------------------------------------------------------------
// Selector parameter numbers and values
// ---------------------------------------------------------------
`define PWGDL_PN_WPS 10'h04d
`define PWGDL_PN_DLS 10'h04e
`define PWGDL_PN_UGRS 10'h0a0
`define PWGDL_WP_STOP 16'h0000
`define PWGDL_WP_LOCK 16'h0001
`define PWGDL_WP_ANY 16'h0002
`define PWGDL_DL_BOTH 16'h0000
`define PWGDL_DL_NOREV 16'h0001
`define PWGDL_DL_NOFWD 16'h0002
`define PWGDL_UG_OPEN 16'h0000
`define PWGDL_RST_SEL 16'h0000

// ---------------------------------------------------------------
// Request kinds and AXI responses
// ---------------------------------------------------------------
`define PWGDL_K_WRITE 2'h0
`define PWGDL_K_PCLR 2'h1
`define PWGDL_K_ACLR 2'h2
`define PWGDL_RESP_OK 2'h0
`define PWGDL_RESP_ERR 2'h2

`endif

//--- verilog/pwgdl_top.v
// Parameter write guard and run-direction lock, with an AXI4-Lite register slave.
// Assumes one 20 MHz clock, a synchronous active-low reset, a parameter store
// outside that takes commit pulses, and start terminals arriving asynchronously.
//
// Summary of operation
// - Selector 0 (reset value): writes accepted only when stopped in keypad unit mode; 75, 77, 160, 296, 297 always.
// - Selector 0: parameters 72, 240, 275 writable running in keypad mode, not External.
// - Selector 1: parameter writes refused, reads still served normally.
// - Selector 1: partial clear and all-parameter clear commands refused.
// - Selector 1: parameters 22, 75, 77, 79, 160, 296, 297 still writable.
// - Selector 2: writes accepted in any mode, running or stopped, except listed ones.
// - Selector 2: listed motor and terminal parameters refused while running.
// - Write-protect selector itself writable in every mode and run state.
// - Both selectors settable only while user-group read selector equals 0.
// - Direction lock 0 allows both, 1 blocks reverse, 2 blocks forward.
// - Direction lock applies to keys, start terminals and communication commands.
`timescale 1ns/100ps
`include "pwgdl_defines.vh"

module pwgdl_top (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire awvalid,
	output wire awready,
	input wire [`PWGDL_ADDR_W-1:0] awaddr,
	input wire [2:0] awprot,
	// AXI4-Lite write data
	input wire wvalid,
	output wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	// AXI4-Lite write response
	output reg bvalid,
	input wire bready,
	output reg [1:0] bresp,
	// AXI4-Lite read address
	input wire arvalid,
	output wire arready,
	input wire [`PWGDL_ADDR_W-1:0] araddr,
	input wire [2:0] arprot,
	// AXI4-Lite read data
	output reg rvalid,
	input wire rready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	// Drive state
	input wire drive_running,
	input wire keypad_unit_mode,
	// Parameter requests from keypad, parameter unit or link
	input wire req_valid,
	input wire [1:0] req_kind,
	input wire [`PWGDL_PNUM_W-1:0] req_param,
	input wire [`PWGDL_VAL_W-1:0] req_value,
	output reg resp_valid,
	output reg resp_error,
	// Commit towards the parameter store
	output reg commit_valid,
	output reg [1:0] commit_kind,
	output reg [`PWGDL_PNUM_W-1:0] commit_param,
	output reg [`PWGDL_VAL_W-1:0] commit_value,
	// Direction commands
	input wire key_forward,
	input wire key_reverse,
	input wire forward_start_input,
	input wire reverse_start_input,
	output reg run_forward,
	output reg run_reverse,
	// Selector values
	output reg [`PWGDL_VAL_W-1:0] write_protect_select,
	output reg [`PWGDL_VAL_W-1:0] direction_lock_select,
	output reg [`PWGDL_VAL_W-1:0] user_group_read_select
);

	// ---------------------------------------------------------------
	// Parameter lists
	// ---------------------------------------------------------------
	function in_sel1_list;
		input [`PWGDL_PNUM_W-1:0] p;
		begin
			case (p)
				10'h016, 10'h04b, 10'h04d, 10'h04f, 10'h0a0, 10'h128, 10'h129: in_sel1_list = 1'b1;
				default: in_sel1_list = 1'b0;
			endcase
		end
	endfunction

	// Always writable under selector 0, whatever the mode and run state.
	function in_sel0_free;
		input [`PWGDL_PNUM_W-1:0] p;
		begin
			case (p)
				10'h04b, 10'h04d, 10'h0a0, 10'h128, 10'h129: in_sel0_free = 1'b1;
				default: in_sel0_free = 1'b0;
			endcase
		end
	endfunction

	function in_sel0_pu_run;
		input [`PWGDL_PNUM_W-1:0] p;
		begin
			case (p)
				10'h048, 10'h0f0, 10'h113: in_sel0_pu_run = 1'b1;
				default: in_sel0_pu_run = 1'b0;
			endcase
		end
	endfunction

	function in_run_block;
		input [`PWGDL_PNUM_W-1:0] p;
		begin
			case (p)
				10'h017, 10'h028, 10'h030, 10'h03c, 10'h03d, 10'h042, 10'h047, 10'h04f,
				10'h060, 10'h115, 10'h124, 10'h125, 10'h12a, 10'h149, 10'h1c2, 10'h21d,
				10'h320, 10'h35b: in_run_block = 1'b1;
				default: in_run_block = ((p >= 10'h050) && (p <= 10'h054)) ||
					((p >= 10'h05a) && (p <= 10'h05e)) ||
					((p >= 10'h0b2) && (p <= 10'h0b8)) ||
					((p >= 10'h0be) && (p <= 10'h0c0));
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Write policy
	// ---------------------------------------------------------------
	// Returns 1 when a write of value v to parameter p may be stored now.
	function write_ok;
		input [`PWGDL_PNUM_W-1:0] p;
		input [`PWGDL_VAL_W-1:0] v;
		input [`PWGDL_VAL_W-1:0] wps;
		input [`PWGDL_VAL_W-1:0] ugrs;
		input run;
		input pu;
		reg pol;
		begin
			pol = 1'b0;
			case (wps)
				`PWGDL_WP_STOP: pol = in_sel0_free(p) ||
					(in_sel0_pu_run(p) && pu) || (!run && pu);
				`PWGDL_WP_LOCK: pol = in_sel1_list(p);
				`PWGDL_WP_ANY: pol = !(run && in_run_block(p));
				default: pol = 1'b0;
			endcase
			if (p == `PWGDL_PN_WPS) begin
				write_ok = (ugrs == `PWGDL_UG_OPEN) && (v <= `PWGDL_WP_ANY);
			end else if (p == `PWGDL_PN_DLS) begin
				write_ok = pol && (ugrs == `PWGDL_UG_OPEN) && (v <= `PWGDL_DL_NOFWD);
			end else begin
				write_ok = pol;
			end
		end
	endfunction

	// ---------------------------------------------------------------
	// Request port
	// ---------------------------------------------------------------
	wire req_write;
	wire req_clear;
	wire req_ok;

	assign req_write = req_kind == `PWGDL_K_WRITE;
	assign req_clear = (req_kind == `PWGDL_K_PCLR) || (req_kind == `PWGDL_K_ACLR);
	assign req_ok = req_write ? write_ok(req_param, req_value, write_protect_select,
		user_group_read_select, drive_running, keypad_unit_mode) :
		(req_clear && (write_protect_select != `PWGDL_WP_LOCK));

	// ---------------------------------------------------------------
	// AXI4-Lite write side
	// ---------------------------------------------------------------
	reg aw_q;
	reg w_q;
	reg [`PWGDL_ADDR_W-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [1:0] dir_cmd_q;
	reg [`PWGDL_CNT_W-1:0] rej_cnt_q;
	reg [`PWGDL_PNUM_W-1:0] last_rej_q;
	wire axi_do;
	reg axi_hit;
	reg axi_sel;
	reg [`PWGDL_PNUM_W-1:0] axi_pnum;
	wire [`PWGDL_VAL_W-1:0] axi_val;
	wire axi_ok;

	assign awready = !aw_q && !bvalid;
	assign wready = !w_q && !bvalid;
	// A pending request from the port goes first so both paths never commit together.
	assign axi_do = aw_q && w_q && !bvalid && !req_valid;
	assign axi_val = wdata_q[`PWGDL_VAL_W-1:0];
	assign axi_ok = axi_sel ? write_ok(axi_pnum, axi_val, write_protect_select,
		user_group_read_select, drive_running, keypad_unit_mode) : axi_hit;

	always @* begin
		axi_hit = 1'b1;
		axi_sel = 1'b1;
		axi_pnum = `PWGDL_PN_WPS;
		case (awaddr_q)
			`PWGDL_OFF_WPS: axi_pnum = `PWGDL_PN_WPS;
			`PWGDL_OFF_DLS: axi_pnum = `PWGDL_PN_DLS;
			`PWGDL_OFF_UGRS: axi_pnum = `PWGDL_PN_UGRS;
			`PWGDL_OFF_DIRCMD: axi_sel = 1'b0;
			default: begin
				axi_sel = 1'b0;
				axi_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= {`PWGDL_ADDR_W{1'b0}};
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `PWGDL_RESP_OK;
		end else begin
			if (awvalid && awready) begin
				aw_q <= 1'b1;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (axi_do) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= axi_ok ? `PWGDL_RESP_OK : `PWGDL_RESP_ERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Selectors and parameter store commits
	// ---------------------------------------------------------------
	// The bus writes only the low half-word; a selector write needs both low lanes.
	wire axi_lanes;
	wire axi_store;
	wire port_store;
	wire [`PWGDL_PNUM_W-1:0] st_param;
	wire [`PWGDL_VAL_W-1:0] st_value;

	assign axi_lanes = wstrb_q[0] && wstrb_q[1];
	assign axi_store = axi_do && axi_sel && axi_ok && axi_lanes;
	assign port_store = req_valid && req_write && req_ok;
	assign st_param = port_store ? req_param : axi_pnum;
	assign st_value = port_store ? req_value : axi_val;

	always @(posedge aclk) begin
		if (!aresetn) begin
			write_protect_select <= `PWGDL_RST_SEL;
			direction_lock_select <= `PWGDL_RST_SEL;
			user_group_read_select <= `PWGDL_RST_SEL;
			dir_cmd_q <= 2'h0;
			resp_valid <= 1'b0;
			resp_error <= 1'b0;
			commit_valid <= 1'b0;
			commit_kind <= `PWGDL_K_WRITE;
			commit_param <= {`PWGDL_PNUM_W{1'b0}};
			commit_value <= {`PWGDL_VAL_W{1'b0}};
		end else begin
			resp_valid <= req_valid;
			resp_error <= req_valid && !req_ok;
			commit_valid <= port_store || axi_store || (req_valid && req_clear && req_ok);
			commit_kind <= req_valid ? req_kind : `PWGDL_K_WRITE;
			commit_param <= st_param;
			commit_value <= st_value;
			// Only accepted writes reach the selectors; a refusal keeps the old value.
			if (port_store || axi_store) begin
				if (st_param == `PWGDL_PN_WPS) begin
					write_protect_select <= st_value;
				end
				if (st_param == `PWGDL_PN_DLS) begin
					direction_lock_select <= st_value;
				end
				if (st_param == `PWGDL_PN_UGRS) begin
					user_group_read_select <= st_value;
				end
			end
			if (axi_do && (awaddr_q == `PWGDL_OFF_DIRCMD) && wstrb_q[0]) begin
				dir_cmd_q <= wdata_q[`PWGDL_DIR_REV:`PWGDL_DIR_FWD];
			end
		end
	end

	// ---------------------------------------------------------------
	// Refusal bookkeeping
	// ---------------------------------------------------------------
	wire port_rej;
	wire axi_rej;

	assign port_rej = req_valid && !req_ok;
	assign axi_rej = axi_do && axi_sel && !axi_ok;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rej_cnt_q <= {`PWGDL_CNT_W{1'b0}};
			last_rej_q <= {`PWGDL_PNUM_W{1'b0}};
		end else if (port_rej || axi_rej) begin
			// Saturates so a flood of refusals never wraps to a small count.
			if (rej_cnt_q != {`PWGDL_CNT_W{1'b1}}) begin
				rej_cnt_q <= rej_cnt_q + 1'b1;
			end
			last_rej_q <= port_rej ? req_param : axi_pnum;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read side
	// ---------------------------------------------------------------
	reg [31:0] rd_d;
	reg rd_hit;

	assign arready = !rvalid;

	always @* begin
		rd_d = 32'h0000_0000;
		rd_hit = 1'b1;
		case (araddr)
			`PWGDL_OFF_WPS: rd_d[`PWGDL_VAL_W-1:0] = write_protect_select;
			`PWGDL_OFF_DLS: rd_d[`PWGDL_VAL_W-1:0] = direction_lock_select;
			`PWGDL_OFF_UGRS: rd_d[`PWGDL_VAL_W-1:0] = user_group_read_select;
			`PWGDL_OFF_DIRCMD: rd_d[`PWGDL_DIR_REV:`PWGDL_DIR_FWD] = dir_cmd_q;
			`PWGDL_OFF_STATUS: begin
				rd_d[`PWGDL_ST_RUN] = drive_running;
				rd_d[`PWGDL_ST_PU] = keypad_unit_mode;
				rd_d[`PWGDL_ST_FWD] = run_forward;
				rd_d[`PWGDL_ST_REV] = run_reverse;
			end
			`PWGDL_OFF_REJCNT: rd_d[`PWGDL_CNT_W-1:0] = rej_cnt_q;
			`PWGDL_OFF_LASTREJ: rd_d[`PWGDL_PNUM_W-1:0] = last_rej_q;
			default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `PWGDL_RESP_OK;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_d;
			rresp <= rd_hit ? `PWGDL_RESP_OK : `PWGDL_RESP_ERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Start terminal synchronisers
	// ---------------------------------------------------------------
	// A change is taken only once the second and third stages agree, which
	// also rejects a single-cycle glitch on the terminal.
	wire [1:0] term_raw;
	wire [1:0] term_sync;

	assign term_raw = {reverse_start_input, forward_start_input};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg t_q;
			assign term_sync[gi] = t_q;
			always @(posedge aclk) begin
				if (!aresetn) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					t_q <= 1'b0;
				end else begin
					s1_q <= term_raw[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						t_q <= s3_q;
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Direction lock
	// ---------------------------------------------------------------
	wire fwd_req;
	wire rev_req;

	assign fwd_req = key_forward || term_sync[0] || dir_cmd_q[`PWGDL_DIR_FWD];
	assign rev_req = key_reverse || term_sync[1] || dir_cmd_q[`PWGDL_DIR_REV];

	always @(posedge aclk) begin
		if (!aresetn) begin
			run_forward <= 1'b0;
			run_reverse <= 1'b0;
		end else begin
			run_forward <= fwd_req && (direction_lock_select != `PWGDL_DL_NOFWD);
			run_reverse <= rev_req && (direction_lock_select != `PWGDL_DL_NOREV);
		end
	end

endmodule

//--- verification/pwgdl_properties.sv
// Concurrent checks on the write guard and direction lock ports.
// Bound to pwgdl_top from the bench top file; sees only top-level ports.
`timescale 1ns/100ps

module pwgdl_properties (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Request port and drive state
	input wire req_valid,
	input wire [1:0] req_kind,
	input wire [9:0] req_param,
	input wire drive_running,
	input wire keypad_unit_mode,
	input wire resp_valid,
	input wire resp_error,
	input wire commit_valid,
	// Selectors and gated run commands
	input wire [15:0] write_protect_select,
	input wire [15:0] direction_lock_select,
	input wire [15:0] user_group_read_select,
	input wire run_forward,
	input wire run_reverse
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire wr = req_valid && req_kind == 2'h0;
	wire [15:0] wp = write_protect_select;

	resp_timing_a: assert property (req_valid |=> resp_valid)
		else $error("request not answered in time");
	refuse_commit_a: assert property (resp_valid && resp_error |-> !commit_valid && $stable(wp))
		else $error("refused request committed");
	lock_clear_a: assert property (req_valid && req_kind != 2'h0 && wp == 16'h0001 |=> resp_error)
		else $error("clear accepted while locked");
	lock_write_a: assert property (wr && wp == 16'h0001 && !(req_param inside {10'h016,
		10'h04b, 10'h04d, 10'h04f, 10'h0a0, 10'h128, 10'h129}) |=> resp_error)
		else $error("write accepted while locked");
	stop_only_a: assert property (wr && wp == 16'h0000 && req_param == 10'h001 |=>
		resp_error == ($past(drive_running) || !$past(keypad_unit_mode)))
		else $error("stop-only policy broken");
	pu_running_a: assert property (wr && wp == 16'h0000 && drive_running &&
		req_param inside {10'h048, 10'h0f0, 10'h113} |=> resp_error != $past(keypad_unit_mode))
		else $error("running keypad exception broken");
	run_list_a: assert property (wr && wp == 16'h0002 && drive_running && req_param inside
		{10'h017, 10'h04f, [10'h050:10'h054], [10'h0b2:10'h0b8], 10'h35b} |=> resp_error)
		else $error("listed parameter written while running");
	group_gate_a: assert property (wr && req_param inside {10'h04d, 10'h04e} &&
		user_group_read_select != 16'h0000 |=> resp_error)
		else $error("selector set with user group active");
	no_reverse_a: assert property (direction_lock_select == 16'h0001 |=> !run_reverse)
		else $error("reverse passed while blocked");
	no_forward_a: assert property (direction_lock_select == 16'h0002 |=> !run_forward)
		else $error("forward passed while blocked");
endmodule

//--- verification/pwgdl_keypad_model.sv
// Behavioural keypad, parameter unit or link master on the request port.
// Assumes the block answers one cycle after each request pulse.
`timescale 1ns/100ps

module pwgdl_keypad_model (
	// Clock
	input wire aclk,
	// Request out
	output reg req_valid,
	output reg [1:0] req_kind,
	output reg [9:0] req_param,
	output reg [15:0] req_value,
	// Answer in
	input wire resp_valid,
	input wire resp_error,
	input wire commit_valid
);
	initial begin
		req_valid = 1'b0;
		req_kind = 2'h0;
		req_param = 10'h000;
		req_value = 16'h0000;
	end

	// Released lines carry the inverse, so a stale value never passes for a fresh one.
	task request(input [1:0] k, input [9:0] p, input [15:0] v, output e, output c, output rv);
		begin
			req_valid <= 1'b1;
			req_kind <= k;
			req_param <= p;
			req_value <= v;
			@(posedge aclk);
			req_valid <= 1'b0;
			req_kind <= ~k;
			req_param <= ~p;
			req_value <= ~v;
			@(posedge aclk);
			rv = resp_valid;
			e = resp_error;
			c = commit_valid;
		end
	endtask
endmodule

//--- verification/param_write_guard_dir_lock_bench.sv
// Self-checking bench for the parameter write guard and direction lock.
// Drives AXI4-Lite and the direction inputs; the keypad model drives requests.
`timescale 1ns/100ps

module param_write_guard_dir_lock_bench;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg [7:0] awaddr = 8'h00, araddr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg drive_running = 1'b0, keypad_unit_mode = 1'b1, key_forward = 1'b0, key_reverse = 1'b0;
	reg forward_start_input = 1'b0, reverse_start_input = 1'b0;
	wire awready, wready, arready, bvalid, rvalid, req_valid, resp_valid, resp_error;
	wire commit_valid, run_forward, run_reverse;
	wire [1:0] bresp, rresp, req_kind, commit_kind;
	wire [15:0] commit_value;
	wire [31:0] rdata;
	wire [9:0] req_param, commit_param;
	wire [15:0] req_value, write_protect_select, direction_lock_select, user_group_read_select;
	integer fail_count = 0, n_compared = 0, i, s, d, l, nrej = 0;
	reg [16:0] rows [0:17];
	reg [1:0] r;
	reg [31:0] rd;
	reg e, c, v;

	always #25 aclk = ~aclk;

	pwgdl_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .drive_running(drive_running),
		.keypad_unit_mode(keypad_unit_mode), .req_valid(req_valid), .req_kind(req_kind),
		.req_param(req_param), .req_value(req_value), .resp_valid(resp_valid),
		.resp_error(resp_error), .commit_valid(commit_valid), .commit_kind(commit_kind),
		.commit_param(commit_param), .commit_value(commit_value), .key_forward(key_forward),
		.key_reverse(key_reverse), .forward_start_input(forward_start_input),
		.reverse_start_input(reverse_start_input), .run_forward(run_forward),
		.run_reverse(run_reverse), .write_protect_select(write_protect_select),
		.direction_lock_select(direction_lock_select),
		.user_group_read_select(user_group_read_select));

	pwgdl_keypad_model pm (.aclk(aclk), .req_valid(req_valid), .req_kind(req_kind),
		.req_param(req_param), .req_value(req_value), .resp_valid(resp_valid),
		.resp_error(resp_error), .commit_valid(commit_valid));

	task chk_bit(input got, input exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task chk_word(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task close_out;
		begin
			$display("compared=%0d failed=%0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0) begin
				$display("All checks passed");
			end else begin
				$display("Checks failed");
			end
			$finish;
		end
	endtask

	task axi_write(input [7:0] a, input [31:0] dt, output [1:0] rsp);
		reg aw, w;
		begin
			aw = 1'b1;
			w = 1'b1;
			awaddr <= a;
			wdata <= dt;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (aw || w) begin
				@(posedge aclk);
				if (aw && awready === 1'b1) begin
					aw = 1'b0;
					awvalid <= 1'b0;
				end
				if (w && wready === 1'b1) begin
					w = 1'b0;
					wvalid <= 1'b0;
				end
			end
			do @(posedge aclk); while (bvalid !== 1'b1);
			rsp = bresp;
		end
	endtask

	task axi_read(input [7:0] a, output [31:0] dt, output [1:0] rsp);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do @(posedge aclk); while (arready !== 1'b1);
			arvalid <= 1'b0;
			do @(posedge aclk); while (rvalid !== 1'b1);
			dt = rdata;
			rsp = rresp;
		end
	endtask

	initial begin
		repeat (6000) @(posedge aclk);
		fail_count = fail_count + 1;
		close_out;
	end

	initial begin
		// Fields: selector, running, keypad mode, kind, parameter, refused.
		rows[0] = {2'h0, 1'b0, 1'b1, 2'h0, 10'h001, 1'b0};
		rows[1] = {2'h0, 1'b1, 1'b1, 2'h0, 10'h001, 1'b1};
		rows[2] = {2'h0, 1'b0, 1'b0, 2'h0, 10'h001, 1'b1};
		rows[3] = {2'h0, 1'b1, 1'b1, 2'h0, 10'h048, 1'b0};
		rows[4] = {2'h0, 1'b1, 1'b0, 2'h0, 10'h0f0, 1'b1};
		rows[5] = {2'h0, 1'b1, 1'b1, 2'h0, 10'h113, 1'b0};
		rows[6] = {2'h0, 1'b0, 1'b1, 2'h1, 10'h000, 1'b0};
		rows[7] = {2'h1, 1'b0, 1'b1, 2'h0, 10'h001, 1'b1};
		rows[8] = {2'h1, 1'b1, 1'b0, 2'h0, 10'h016, 1'b0};
		rows[9] = {2'h1, 1'b1, 1'b0, 2'h0, 10'h129, 1'b0};
		rows[10] = {2'h1, 1'b1, 1'b0, 2'h0, 10'h04f, 1'b0};
		rows[11] = {2'h1, 1'b0, 1'b1, 2'h1, 10'h000, 1'b1};
		rows[12] = {2'h1, 1'b0, 1'b1, 2'h2, 10'h000, 1'b1};
		rows[13] = {2'h2, 1'b1, 1'b0, 2'h0, 10'h001, 1'b0};
		rows[14] = {2'h2, 1'b1, 1'b1, 2'h0, 10'h05c, 1'b1};
		rows[15] = {2'h2, 1'b1, 1'b1, 2'h0, 10'h0c0, 1'b1};
		rows[16] = {2'h2, 1'b1, 1'b0, 2'h0, 10'h35b, 1'b1};
		rows[17] = {2'h2, 1'b0, 1'b0, 2'h0, 10'h35b, 1'b0};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_read(8'h00, rd, r);
		chk_word(rd, 32'h0);
		axi_read(8'h04, rd, r);
		chk_word(rd, 32'h0);
		axi_read(8'h1c, rd, r);
		chk_word({30'h0, r}, 32'h2);
		for (i = 0; i < 18; i = i + 1) begin
			axi_write(8'h00, {30'h0, rows[i][16:15]}, r);
			chk_word({30'h0, r}, 32'h0);
			drive_running <= rows[i][14];
			keypad_unit_mode <= rows[i][13];
			pm.request(rows[i][12:11], rows[i][10:1], 16'h0005, e, c, v);
			chk_bit(v, 1'b1);
			chk_bit(e, rows[i][0]);
			chk_bit(c, ~rows[i][0]);
			nrej = nrej + rows[i][0];
			if (!rows[i][0]) begin
				chk_word({30'h0, commit_kind}, {30'h0, rows[i][12:11]});
				if (rows[i][12:11] == 2'h0) begin
					chk_word({6'h0, commit_param, commit_value}, {6'h0, rows[i][10:1], 16'h0005});
				end
			end
		end
		axi_read(8'h14, rd, r);
		chk_word(rd, nrej);
		axi_read(8'h18, rd, r);
		chk_word(rd, 32'h35b);
		pm.request(2'h0, 10'h04d, 16'h0002, e, c, v);
		chk_bit(e, 1'b0);
		axi_write(8'h08, 32'h1, r);
		axi_write(8'h00, 32'h0, r);
		chk_word({30'h0, r}, 32'h2);
		pm.request(2'h0, 10'h04e, 16'h0001, e, c, v);
		chk_bit(e, 1'b1);
		axi_read(8'h00, rd, r);
		chk_word(rd, 32'h2);
		axi_write(8'h08, 32'h0, r);
		drive_running <= 1'b0;
		keypad_unit_mode <= 1'b1;
		for (l = 0; l < 3; l = l + 1) begin
			axi_write(8'h04, l, r);
			chk_word({30'h0, r}, 32'h0);
			for (s = 0; s < 3; s = s + 1) begin
				for (d = 0; d < 2; d = d + 1) begin
					if (s == 0) begin
						key_forward <= (d == 0);
						key_reverse <= (d == 1);
					end else if (s == 1) begin
						forward_start_input <= (d == 0);
						reverse_start_input <= (d == 1);
					end else begin
						axi_write(8'h0c, {30'h0, d == 1, d == 0}, r);
					end
					repeat (8) @(posedge aclk);
					chk_bit(run_forward, d == 0 && l != 2);
					chk_bit(run_reverse, d == 1 && l != 1);
					key_forward <= 1'b0;
					key_reverse <= 1'b0;
					forward_start_input <= 1'b0;
					reverse_start_input <= 1'b0;
					if (s == 2) axi_write(8'h0c, 32'h0, r);
					repeat (8) @(posedge aclk);
				end
			end
		end
		// Mid-run reset must bring both selectors back to their reset values.
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_read(8'h04, rd, r);
		chk_word(rd, 32'h0);
		axi_read(8'h00, rd, r);
		chk_word(rd, 32'h0);
		close_out;
	end
endmodule

bind pwgdl_top pwgdl_properties u_chk (.aclk(aclk), .aresetn(aresetn),
	.req_valid(req_valid), .req_kind(req_kind), .req_param(req_param),
	.drive_running(drive_running), .keypad_unit_mode(keypad_unit_mode),
	.resp_valid(resp_valid), .resp_error(resp_error), .commit_valid(commit_valid),
	.write_protect_select(write_protect_select), .direction_lock_select(direction_lock_select),
	.user_group_read_select(user_group_read_select), .run_forward(run_forward),
	.run_reverse(run_reverse));
